// file: inc/cfs_pkg.sv
`default_nettype none
package cfs_pkg;
   // settings are coded in tenths of a second / plain codes
   localparam int SET_W = 14;
   localparam logic [13:0] DISABLE_CODE = 14'h270F;
   localparam logic [13:0] KEEP_SPEED_CODE = 14'h270F;
   localparam logic [13:0] ZERO_INTERVAL = 14'h0000;
   localparam logic [13:0] CNT_RESET = 14'h0000;
   localparam logic [13:0] CNT_ONE = 14'h0001;
   localparam logic [13:0] SPEED_RESET = 14'h0000;

   localparam logic [1:0] MODE_COAST = 2'h0;
   localparam logic [1:0] MODE_DECEL_FAULT = 2'h1;
   localparam logic [1:0] MODE_DECEL_RESTART = 2'h2;
   localparam logic [1:0] MODE_FALLBACK = 2'h3;

   localparam logic NVW_BOTH = 1'h0;
   localparam logic NVW_RAM_ONLY = 1'h1;

   // history codes: values are arbitrary
   localparam logic [7:0] HIST_EMPTY = 8'h00;
   localparam logic [7:0] LINK_FAULT_ENTRY = 8'h50;

   localparam int TICK_TIME_US = 100000;
   localparam int CLK_FREQ_MHZ = 40;
   localparam int TICK_CYCLES_DEF = TICK_TIME_US * CLK_FREQ_MHZ;
   localparam int TICK_CNT_W = 22;
   localparam logic [21:0] TICK_CNT_RESET = 22'h000000;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_COAST,
      ST_DECEL,
      ST_HALT,
      ST_WAIT,
      ST_FALLBK
   } cfs_state_t;
endpackage
`default_nettype wire

// file: inc/cfs_sup_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cfs_sup_if (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce
);
   logic tick;
   logic frame;
   logic net_mode;
   logic [13:0] interval;
   logic expired;
   logic armed;
   logic hist_store;
   logic hist_temp;
   logic [7:0] hist_display;

   modport top_mp (
      input clk, rst_n, ce, expired, armed, hist_display,
      output tick, frame, net_mode, interval, hist_store, hist_temp
   );
   modport timer_mp (
      input clk, rst_n, ce, tick, frame, net_mode, interval,
      output expired, armed
   );
   modport hist_mp (
      input clk, rst_n, ce, hist_store, hist_temp,
      output hist_display
   );
endinterface
`default_nettype wire

// file: hw/cfs_loss_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cfs_loss_timer (
   cfs_sup_if.timer_mp sif
);
   logic armed_reg, armed_next;
   logic expired_reg, expired_next;
   logic [13:0] cnt_reg, cnt_next;
   logic live;

   always_comb begin
      live = (sif.interval != cfs_pkg::DISABLE_CODE) &&
             (sif.interval != cfs_pkg::ZERO_INTERVAL);
      armed_next = armed_reg;
      cnt_next = cnt_reg;
      expired_next = expired_reg;
      if (!sif.net_mode || !live) begin
         armed_next = 1'b0;
         cnt_next = cfs_pkg::CNT_RESET;
         expired_next = 1'b0;
      end else if (sif.frame) begin
         armed_next = 1'b1;
         cnt_next = cfs_pkg::CNT_RESET;
         expired_next = 1'b0;
      end else if (armed_reg && sif.tick) begin
         if (cnt_reg != 14'h3FFF) begin
            cnt_next = cnt_reg + cfs_pkg::CNT_ONE;
         end
         expired_next = expired_reg || (cnt_next >= sif.interval);
      end
   end

   always_ff @(posedge sif.clk) begin
      if (!sif.rst_n) begin
         armed_reg <= 1'b0;
         expired_reg <= 1'b0;
         cnt_reg <= cfs_pkg::CNT_RESET;
      end else if (sif.ce) begin
         armed_reg <= armed_next;
         expired_reg <= expired_next;
         cnt_reg <= cnt_next;
      end
   end

   assign sif.armed = armed_reg;
   assign sif.expired = expired_reg;

   a_expire_needs_arm: assert property (@(posedge sif.clk)
      disable iff (!sif.rst_n) expired_reg |-> armed_reg)
      else $error("loss timeout without an armed timer");
endmodule
`default_nettype wire

// file: hw/cfs_fault_hist.sv
`timescale 1ns/10ps
`default_nettype none
module cfs_fault_hist (
   cfs_sup_if.hist_mp sif
);
   logic [7:0] latest_reg, latest_next;
   logic [7:0] display_reg, display_next;

   // temporary overlay never touches the stored entry
   always_comb begin
      latest_next = sif.hist_store ? cfs_pkg::LINK_FAULT_ENTRY
                                   : latest_reg;
      display_next = sif.hist_temp ? cfs_pkg::LINK_FAULT_ENTRY
                                   : latest_next;
   end

   always_ff @(posedge sif.clk) begin
      if (!sif.rst_n) begin
         latest_reg <= cfs_pkg::HIST_EMPTY;
         display_reg <= cfs_pkg::HIST_EMPTY;
      end else if (sif.ce) begin
         latest_reg <= latest_next;
         display_reg <= display_next;
      end
   end

   assign sif.hist_display = display_reg;
endmodule
`default_nettype wire

// file: hw/cfs_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - loss interval at disable code means no loss supervision at all.
// - interval zero faults as soon as network control mode is entered.
// - set interval with no frame received in time trips the link fault.
// - any received frame, any station number, restarts the loss timer.
// - supervision starts at the first frame in network control mode.
// - stop mode picks coast, decel with/without fault, or fallback speed.
// - on clearing, modes 0/1 stay faulted, 2 restarts, 3 runs normally.
// - mode 3 raises the alarm output on a link error.
// - with fault output, the fault entry is stored permanently in history.
// - mode 2 shows the fault in history only while waiting at stop; mode 3 never shows it.
// - modes 1-3 use ordinary deceleration and acceleration ramps.
// - modes 2 and 3 restart with the run and speed in effect before.
// - mode 2 reaccelerates at once if the error clears while slowing.
// - mode 3 with both limits disabled never switches to fallback speed.
// - fallback speed overrides any speed source, terminals included.
// - write select 0 writes nonvolatile and RAM, 1 writes RAM only.
// - RAM-only values vanish at power-off; nonvolatile values return.
// - errors beyond the retry limit trip; disable code gives alarm only.
// - fallback code 9999 keeps the speed that was in use.
module cfs_supervisor #(
   parameter int TICK_CYCLES = cfs_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic frame_rx,
   input wire logic rx_error,
   input wire logic net_mode,
   input wire logic at_stop,
   input wire logic run_cmd,
   input wire logic [13:0] speed_cmd,
   input wire logic [13:0] loss_check_interval,
   input wire logic [13:0] retry_limit,
   input wire logic [1:0] link_fault_stop_mode,
   input wire logic [13:0] fallback_speed,
   input wire logic nonvolatile_write_select,
   input wire logic param_wr,
   input wire logic [7:0] param_addr,
   input wire logic [15:0] param_data,
   output logic run_out,
   output logic [13:0] speed_out,
   output logic coast_req,
   output logic decel_req,
   output logic fault_output,
   output logic link_fault_code,
   output logic link_alarm_output,
   output logic [7:0] hist_display,
   output logic nv_wr_en,
   output logic ram_wr_en,
   output logic [7:0] wr_addr,
   output logic [15:0] wr_data
);
   localparam logic [21:0] TICK_LAST = 22'(TICK_CYCLES - 1);

   cfs_sup_if sif (.clk(clk), .rst_n(rst_n), .ce(ce));

   cfs_loss_timer u_timer (.sif(sif.timer_mp));
   cfs_fault_hist u_hist (.sif(sif.hist_mp));

   ////////////////////////////////////////////////////////////////////
   // tick prescaler

   logic [21:0] tick_cnt_reg, tick_cnt_next;
   logic tick_reg, tick_next;

   always_comb begin
      tick_next = (tick_cnt_reg == TICK_LAST);
      tick_cnt_next = tick_next ? cfs_pkg::TICK_CNT_RESET
                                : tick_cnt_reg + 22'h000001;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_cnt_reg <= cfs_pkg::TICK_CNT_RESET;
         tick_reg <= 1'b0;
      end else if (ce) begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign sif.tick = tick_reg;
   assign sif.frame = frame_rx;
   assign sif.net_mode = net_mode;
   assign sif.interval = loss_check_interval;

   ////////////////////////////////////////////////////////////////////
   // consecutive receive errors

   logic [13:0] err_cnt_reg, err_cnt_next;
   logic retry_over_reg, retry_over_next;
   logic retry_alarm_reg, retry_alarm_next;
   logic retry_on;

   always_comb begin
      retry_on = (retry_limit != cfs_pkg::DISABLE_CODE);
      err_cnt_next = err_cnt_reg;
      if (frame_rx && rx_error) begin
         if (err_cnt_reg != 14'h3FFF) begin
            err_cnt_next = err_cnt_reg + cfs_pkg::CNT_ONE;
         end
      end else if (frame_rx) begin
         err_cnt_next = cfs_pkg::CNT_RESET;
      end
      retry_over_next = retry_on && (err_cnt_next > retry_limit);
      // an error in the same cycle as a good frame still sets
      retry_alarm_next = retry_alarm_reg;
      if (frame_rx && rx_error && !retry_on) begin
         retry_alarm_next = 1'b1;
      end else if (frame_rx || retry_on) begin
         retry_alarm_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_cnt_reg <= cfs_pkg::CNT_RESET;
         retry_over_reg <= 1'b0;
         retry_alarm_reg <= 1'b0;
      end else if (ce) begin
         err_cnt_reg <= err_cnt_next;
         retry_over_reg <= retry_over_next;
         retry_alarm_reg <= retry_alarm_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fault response

   cfs_pkg::cfs_state_t state_reg, state_next;
   logic [1:0] mode_reg, mode_next;
   logic saved_run_reg, saved_run_next;
   logic [13:0] saved_speed_reg, saved_speed_next;
   logic restore_reg, restore_next;
   logic run_next, coast_next, decel_next, fault_next, ind_next;
   logic alarm_next;
   logic [13:0] speed_next;
   logic zero_fault, err_now, fallback_ok;

   always_comb begin
      zero_fault = net_mode &&
                   (loss_check_interval == cfs_pkg::ZERO_INTERVAL);
      err_now = sif.expired || zero_fault || retry_over_reg;
      fallback_ok = !((retry_limit == cfs_pkg::DISABLE_CODE) &&
         (loss_check_interval == cfs_pkg::DISABLE_CODE));
      state_next = state_reg;
      mode_next = mode_reg;
      saved_run_next = saved_run_reg;
      saved_speed_next = saved_speed_reg;
      restore_next = restore_reg;
      case (state_reg)
         cfs_pkg::ST_RUN: begin
            if (restore_reg && ((run_cmd != saved_run_reg) ||
                (speed_cmd != saved_speed_reg))) begin
               restore_next = 1'b0;
            end
            if (err_now) begin
               mode_next = link_fault_stop_mode;
               saved_run_next = run_out;
               saved_speed_next = speed_out;
               case (link_fault_stop_mode)
                  cfs_pkg::MODE_COAST: state_next = cfs_pkg::ST_COAST;
                  cfs_pkg::MODE_FALLBACK: begin
                     if (fallback_ok) begin
                        state_next = cfs_pkg::ST_FALLBK;
                     end
                  end
                  default: state_next = cfs_pkg::ST_DECEL;
               endcase
            end
         end
         cfs_pkg::ST_DECEL: begin
            if (mode_reg == cfs_pkg::MODE_DECEL_RESTART && !err_now) begin
               state_next = cfs_pkg::ST_RUN;
               restore_next = 1'b1;
            end else if (at_stop) begin
               state_next = (mode_reg == cfs_pkg::MODE_DECEL_FAULT) ?
                  cfs_pkg::ST_HALT : cfs_pkg::ST_WAIT;
            end
         end
         cfs_pkg::ST_WAIT, cfs_pkg::ST_FALLBK: begin
            if (!err_now) begin
               state_next = cfs_pkg::ST_RUN;
               restore_next = 1'b1;
            end
         end
         // coast and halt hold until reset
         cfs_pkg::ST_COAST, cfs_pkg::ST_HALT: state_next = state_reg;
         default: state_next = cfs_pkg::ST_RUN;
      endcase

      coast_next = (state_next == cfs_pkg::ST_COAST);
      decel_next = (state_next == cfs_pkg::ST_DECEL);
      fault_next = coast_next || (state_next == cfs_pkg::ST_HALT);
      ind_next = fault_next || (state_next == cfs_pkg::ST_WAIT);
      alarm_next = retry_alarm_reg || (err_now &&
         link_fault_stop_mode == cfs_pkg::MODE_FALLBACK);
      run_next = 1'b0;
      speed_next = cfs_pkg::SPEED_RESET;
      case (state_next)
         cfs_pkg::ST_RUN: begin
            run_next = restore_next ? saved_run_next : run_cmd;
            speed_next = restore_next ? saved_speed_next : speed_cmd;
         end
         cfs_pkg::ST_FALLBK: begin
            run_next = 1'b1;
            speed_next = (fallback_speed == cfs_pkg::KEEP_SPEED_CODE) ?
               saved_speed_next : fallback_speed;
         end
         default: begin
            run_next = 1'b0;
            speed_next = cfs_pkg::SPEED_RESET;
         end
      endcase
   end

   assign sif.hist_store = fault_next && !fault_output;
   assign sif.hist_temp = (state_next == cfs_pkg::ST_WAIT);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= cfs_pkg::ST_RUN;
         mode_reg <= cfs_pkg::MODE_COAST;
         saved_run_reg <= 1'b0;
         saved_speed_reg <= cfs_pkg::SPEED_RESET;
         restore_reg <= 1'b0;
         run_out <= 1'b0;
         speed_out <= cfs_pkg::SPEED_RESET;
         coast_req <= 1'b0;
         decel_req <= 1'b0;
         fault_output <= 1'b0;
         link_fault_code <= 1'b0;
         link_alarm_output <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         saved_run_reg <= saved_run_next;
         saved_speed_reg <= saved_speed_next;
         restore_reg <= restore_next;
         run_out <= run_next;
         speed_out <= speed_next;
         coast_req <= coast_next;
         decel_req <= decel_next;
         fault_output <= fault_next;
         link_fault_code <= ind_next;
         link_alarm_output <= alarm_next;
      end
   end

   assign hist_display = sif.hist_display;

   ////////////////////////////////////////////////////////////////////
   // parameter write routing; nothing here reloads RAM at power-up

   logic nv_next, ram_next;

   always_comb begin
      ram_next = param_wr;
      nv_next = param_wr &&
         (nonvolatile_write_select == cfs_pkg::NVW_BOTH);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nv_wr_en <= 1'b0;
         ram_wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 16'h0000;
      end else if (ce) begin
         nv_wr_en <= nv_next;
         ram_wr_en <= ram_next;
         if (param_wr) begin
            wr_addr <= param_addr;
            wr_data <= param_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_disable_no_loss: assert property (
      (ce && loss_check_interval == cfs_pkg::DISABLE_CODE) |=> !sif.expired)
      else $error("loss timeout while supervision disabled");
   a_zero_trips_now: assert property (
      (ce && zero_fault && state_reg == cfs_pkg::ST_RUN &&
       link_fault_stop_mode == cfs_pkg::MODE_COAST) |=>
      (fault_output && coast_req && link_fault_code))
      else $error("zero interval did not trip at once");
   a_frame_clears_loss: assert property (
      (ce && frame_rx && net_mode) |=> (!sif.expired && sif.armed) ||
      $past(loss_check_interval) == cfs_pkg::DISABLE_CODE ||
      $past(loss_check_interval) == cfs_pkg::ZERO_INTERVAL)
      else $error("frame did not restart loss timer");
   a_no_arm_offline: assert property (
      (ce && !net_mode) |=> !sif.armed)
      else $error("timer armed outside network mode");
   a_decel_no_fault: assert property (
      (ce && state_reg == cfs_pkg::ST_DECEL && !at_stop) |=> !fault_output)
      else $error("fault output before the stop");
   a_halt_held: assert property (
      (state_reg == cfs_pkg::ST_HALT) |=>
      (state_reg == cfs_pkg::ST_HALT && fault_output && link_fault_code))
      else $error("halted fault not held");
   a_alarm_mode3: assert property (
      (ce && err_now && link_fault_stop_mode == cfs_pkg::MODE_FALLBACK)
      |=> link_alarm_output)
      else $error("alarm missing in fallback mode");
   a_store_at_fault: assert property (
      $rose(fault_output) |-> hist_display == cfs_pkg::LINK_FAULT_ENTRY)
      else $error("fault entry not stored with fault output");
   a_mode2_resume: assert property (
      (ce && state_reg == cfs_pkg::ST_DECEL && !err_now &&
       mode_reg == cfs_pkg::MODE_DECEL_RESTART) |=>
      (state_reg == cfs_pkg::ST_RUN && run_out == $past(saved_run_reg)))
      else $error("mode 2 did not reaccelerate");
   a_no_fallback: assert property (
      (ce && !fallback_ok && state_reg != cfs_pkg::ST_FALLBK) |=>
      state_reg != cfs_pkg::ST_FALLBK)
      else $error("fallback entered with both checks disabled");
   a_fallback_speed: assert property (
      (ce && state_reg == cfs_pkg::ST_FALLBK && err_now &&
       fallback_speed != cfs_pkg::KEEP_SPEED_CODE) |=>
      speed_out == $past(fallback_speed))
      else $error("fallback speed not applied");
   a_ram_only: assert property (
      (ce && param_wr && nonvolatile_write_select == cfs_pkg::NVW_RAM_ONLY)
      |=> (ram_wr_en && !nv_wr_en))
      else $error("nonvolatile write in RAM-only mode");
   a_retry_trip: assert property (
      (ce && frame_rx && rx_error && retry_on &&
       err_cnt_reg >= retry_limit && err_cnt_reg != 14'h3FFF) |=>
      retry_over_reg)
      else $error("retry limit exceeded without trip");
endmodule
`default_nettype wire

// file: sim/cfs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cfs_host_model (
   input wire logic clk,
   input wire logic enable,
   output logic frame_rx,
   output logic rx_error
);
   int gap_cnt = 0;
   logic one_req = 1'b0;
   logic one_err = 1'b0;
   // one frame every third cycle keeps inside any check interval of 2 or more 4-cycle ticks
   always @(negedge clk) begin
      frame_rx <= (enable && gap_cnt == 0) || one_req;
      rx_error <= one_req && one_err;
      gap_cnt <= (gap_cnt == 2) ? 0 : gap_cnt + 1;
   end
   // single frame, optionally with a receive error
   task automatic send(input logic err);
      @(posedge clk);
      one_err = err;
      one_req = 1'b1;
      @(posedge clk);
      one_req = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: sim/comm_fault_supervisor_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
 $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module comm_fault_supervisor_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic host_en = 1'b0;
   logic frame_rx, rx_error;
   logic net_mode = 1'b0;
   logic at_stop = 1'b0;
   logic run_cmd = 1'b0;
   logic [13:0] speed_cmd = 14'h0000;
   logic [13:0] ivl = cfs_pkg::DISABLE_CODE;
   logic [13:0] rlim = cfs_pkg::DISABLE_CODE;
   logic [1:0] mode = 2'h0;
   logic [13:0] fb = 14'h0055;
   logic nvsel = 1'b0;
   logic param_wr = 1'b0;
   logic [7:0] param_addr = 8'h00;
   logic [15:0] param_data = 16'h0000;
   logic run_out, coast_req, decel_req, fault_output, link_fault_code;
   logic link_alarm_output, nv_wr_en, ram_wr_en;
   logic [13:0] speed_out;
   logic [7:0] hist_display, wr_addr;
   logic [15:0] wr_data;
   int fail_count = 0;
   int check_count = 0;
   always #12.5 clk = ~clk;
   cfs_host_model u_cfs_host_model (.clk(clk), .enable(host_en),
      .frame_rx(frame_rx), .rx_error(rx_error));
   cfs_supervisor #(.TICK_CYCLES(4)) u_cfs_supervisor (.clk(clk),
      .rst_n(rst_n), .ce(ce), .frame_rx(frame_rx), .rx_error(rx_error),
      .net_mode(net_mode), .at_stop(at_stop), .run_cmd(run_cmd),
      .speed_cmd(speed_cmd), .loss_check_interval(ivl), .retry_limit(rlim),
      .link_fault_stop_mode(mode), .fallback_speed(fb),
      .nonvolatile_write_select(nvsel), .param_wr(param_wr),
      .param_addr(param_addr), .param_data(param_data), .run_out(run_out),
      .speed_out(speed_out), .coast_req(coast_req), .decel_req(decel_req),
      .fault_output(fault_output), .link_fault_code(link_fault_code),
      .link_alarm_output(link_alarm_output), .hist_display(hist_display),
      .nv_wr_en(nv_wr_en), .ram_wr_en(ram_wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data));
   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // every scenario except t_param starts from reset: modes 0/1 only leave by reset
   task automatic setup(input logic [1:0] m, input logic [13:0] i,
         input logic [13:0] r);
      rst_n = 1'b0;
      mode = m;
      ivl = i;
      rlim = r;
      fb = 14'h0055;
      host_en = 1'b0;
      at_stop = 1'b0;
      net_mode = 1'b1;
      run_cmd = 1'b1;
      speed_cmd = 14'h0123;
      tick(5);
      rst_n = 1'b1;
      tick(1);
   endtask
   task automatic send(input logic err);
      u_cfs_host_model.send(err);
      tick(3);
   endtask
   task automatic t_param(input logic sel);
      @(negedge clk);
      nvsel = sel;
      param_wr = 1'b1;
      param_addr = {7'h1E, sel};
      param_data = {15'h52F8, sel};
      @(negedge clk);
      param_wr = 1'b0;
      `CHK(ram_wr_en, 1'b1)
      `CHK(nv_wr_en, ~sel)
      `CHK(wr_data, {15'h52F8, sel})
      `CHK(wr_addr, {7'h1E, sel})
      tick(1);
      `CHK(ram_wr_en, 1'b0)
      $display("test param sel=%0d done", sel);
   endtask
   task automatic t_off_and_zero;
      setup(2'h0, cfs_pkg::DISABLE_CODE, 14'h0005);
      `CHK(fault_output, 1'b0)
      send(1'b0);
      tick(40);
      `CHK({coast_req, fault_output, run_out}, 3'b001)
      setup(2'h0, cfs_pkg::ZERO_INTERVAL, cfs_pkg::DISABLE_CODE);
      tick(3);
      `CHK({coast_req, fault_output, link_fault_code}, 3'b111)
      `CHK(hist_display, cfs_pkg::LINK_FAULT_ENTRY)
      net_mode = 1'b0;
      send(1'b0);
      tick(3);
      `CHK({coast_req, fault_output, run_out}, 3'b110)
      $display("test disable/zero done");
   endtask
   task automatic t_mode1;
      setup(2'h1, 14'h0002, cfs_pkg::DISABLE_CODE);
      tick(40);
      `CHK(decel_req, 1'b0)
      host_en = 1'b1;
      tick(60);
      `CHK({decel_req, fault_output}, 2'b00)
      host_en = 1'b0;
      tick(20);
      `CHK({decel_req, fault_output}, 2'b10)
      at_stop = 1'b1;
      tick(3);
      `CHK({fault_output, link_fault_code}, 2'b11)
      `CHK(hist_display, cfs_pkg::LINK_FAULT_ENTRY)
      send(1'b0);
      `CHK({fault_output, run_out}, 2'b10)
      $display("test mode1 done");
   endtask
   task automatic t_mode2;
      setup(2'h2, 14'h0002, cfs_pkg::DISABLE_CODE);
      send(1'b0);
      tick(20);
      `CHK({decel_req, fault_output}, 2'b10)
      send(1'b0);
      `CHK({decel_req, run_out}, 2'b01)
      `CHK(speed_out, 14'h0123)
      tick(20);
      at_stop = 1'b1;
      tick(3);
      `CHK({link_fault_code, fault_output}, 2'b10)
      `CHK(hist_display, cfs_pkg::LINK_FAULT_ENTRY)
      at_stop = 1'b0;
      send(1'b0);
      `CHK({link_fault_code, run_out}, 2'b01)
      `CHK(hist_display, cfs_pkg::HIST_EMPTY)
      $display("test mode2 done");
   endtask
   task automatic t_mode3;
      setup(2'h3, 14'h0002, cfs_pkg::DISABLE_CODE);
      speed_cmd = 14'h0123;
      send(1'b0);
      tick(20);
      `CHK({run_out, link_alarm_output, fault_output}, 3'b110)
      `CHK(speed_out, 14'h0055)
      `CHK(link_fault_code, 1'b0)
      fb = cfs_pkg::KEEP_SPEED_CODE;
      send(1'b0);
      `CHK({run_out, link_alarm_output}, 2'b10)
      `CHK(speed_out, 14'h0123)
      tick(20);
      `CHK(speed_out, 14'h0123)
      `CHK(link_alarm_output, 1'b1)
      $display("test mode3 done");
   endtask
   task automatic t_retry;
      setup(2'h0, cfs_pkg::DISABLE_CODE, 14'h0001);
      send(1'b1);
      `CHK(coast_req, 1'b0)
      send(1'b1);
      `CHK({coast_req, fault_output}, 2'b11)
      setup(2'h3, cfs_pkg::DISABLE_CODE, cfs_pkg::DISABLE_CODE);
      send(1'b1);
      `CHK({link_alarm_output, run_out, fault_output}, 3'b110)
      `CHK(speed_out, 14'h0123)
      send(1'b0);
      `CHK(link_alarm_output, 1'b0)
      $display("test retry done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // whole sequence needs well under 2000 cycles
   initial begin
      #(25 * 6000);
      fail_count++;
      give_verdict;
   end
   initial begin
      setup(2'h0, cfs_pkg::DISABLE_CODE, cfs_pkg::DISABLE_CODE);
      `CHK({run_out, fault_output, hist_display}, 10'h200)
      t_param(cfs_pkg::NVW_BOTH);
      t_param(cfs_pkg::NVW_RAM_ONLY);
      t_off_and_zero;
      t_mode1;
      t_mode2;
      t_mode3;
      t_retry;
      give_verdict;
   end
endmodule
`default_nettype wire
